// File: logic/cfdec_map.vh
// constants for the condition, operand field and prefix decoder
// assumes includers switch implicit nets off themselves
`ifndef CFDEC_MAP_VH
`define CFDEC_MAP_VH
// ----------------------------------------
// condition codes
// ----------------------------------------
`define CFDEC_CC_NEVER 4'h0
`define CFDEC_CC_SBELOW 4'h1
`define CFDEC_CC_SATMOST 4'h2
`define CFDEC_CC_UATMOST 4'h3
`define CFDEC_CC_PV_SET 4'h4
`define CFDEC_CC_SIGN_SET 4'h5
`define CFDEC_CC_ZERO_SET 4'h6
`define CFDEC_CC_CARRY_SET 4'h7
`define CFDEC_CC_ALWAYS 4'h8
`define CFDEC_CC_SNOTBELOW 4'h9
`define CFDEC_CC_SABOVE 4'hA
`define CFDEC_CC_UABOVE 4'hB
`define CFDEC_CC_PV_CLR 4'hC
`define CFDEC_CC_SIGN_CLR 4'hD
`define CFDEC_CC_ZERO_CLR 4'hE
`define CFDEC_CC_CARRY_CLR 4'hF
// ----------------------------------------
// register select one-hot positions
// ----------------------------------------
`define CFDEC_RS_CNT 0
`define CFDEC_RS_SEC 1
`define CFDEC_RS_MAIN 2
`define CFDEC_RS_IXF 3
`define CFDEC_RS_IXS 4
`define CFDEC_RS_STK 5
`define CFDEC_RS_AF 6
`define CFDEC_RS_W 7
`define CFDEC_PAIR_CNT 3'h0
`define CFDEC_PAIR_SEC 3'h1
`define CFDEC_PAIR_MAIN 3'h2
`define CFDEC_PAIR_IXF 3'h4
`define CFDEC_PAIR_IXS 3'h5
`define CFDEC_PAIR_SIX 3'h6
`define CFDEC_REG_ACC 3'h6
`define CFDEC_REG_LAST 3'h5
`define CFDEC_IDX_FIRST 2'h0
`define CFDEC_IDX_SECOND 2'h1
`define CFDEC_IDX_STACK 2'h2
// ----------------------------------------
// prefix ranges and address constants
// ----------------------------------------
`define CFDEC_PFX_LO 8'hE0
`define CFDEC_PFX_HI 8'hFE
`define CFDEC_SRC_A_HI 8'hE7
`define CFDEC_DST_A_LO 8'hE8
`define CFDEC_DST_A_HI 8'hEF
`define CFDEC_SRC_B_LO 8'hF0
`define CFDEC_SRC_B_HI 8'hF3
`define CFDEC_DST_B_LO 8'hF4
`define CFDEC_DST_B_HI 8'hF7
`define CFDEC_REG_LO 8'hF8
`define CFDEC_BLOCK_PFX 8'hFE
`define CFDEC_DIRECT_PAGE 8'hFF
`define CFDEC_REL_BIAS 16'h0002
// second bytes of block ops (0x58-0x5F) and conditional return (0xD0-0xDF)
`define CFDEC_BLK_TOP 5'h0B
`define CFDEC_RET_TOP 4'hD
// flag bit positions within flag_in / flag_out
`define CFDEC_FB_SIGN 7
`define CFDEC_FB_ZERO 6
`define CFDEC_FB_PV 2
`define CFDEC_FB_CARRY 0
// flag actions
`define CFDEC_FA_KEEP 3'h0
`define CFDEC_FA_ZERO 3'h1
`define CFDEC_FA_ONE 3'h2
`define CFDEC_FA_CALC 3'h3
`define CFDEC_FA_UNDEF 3'h4
// timing
`define CFDEC_STATE_NS 200
`define CFDEC_CLK_NS 40
`endif

// File: logic/cfdec_cond.v
// condition evaluator: one four-bit condition code against the flags
// assumes flags come from the same clock domain, already registered
`default_nettype none
module cfdec_cond (
  input wire [3:0] cc,
  input wire sign,
  input wire zero,
  input wire pv,
  input wire carry,
  output reg taken
);
`include "cfdec_map.vh"
  wire sx;
  assign sx = sign ^ pv;
  // ----------------------------------------
  // code table
  // ----------------------------------------
  always @* begin
    case (cc)
      `CFDEC_CC_NEVER: taken = 1'b0;
      `CFDEC_CC_SBELOW: taken = sx;
      `CFDEC_CC_SATMOST: taken = zero | sx;
      `CFDEC_CC_UATMOST: taken = carry | zero;
      `CFDEC_CC_PV_SET: taken = pv;
      `CFDEC_CC_SIGN_SET: taken = sign;
      `CFDEC_CC_ZERO_SET: taken = zero;
      `CFDEC_CC_CARRY_SET: taken = carry;
      `CFDEC_CC_ALWAYS: taken = 1'b1;
      `CFDEC_CC_SNOTBELOW: taken = ~sx;
      `CFDEC_CC_SABOVE: taken = ~(zero | sx);
      `CFDEC_CC_UABOVE: taken = ~(carry | zero);
      `CFDEC_CC_PV_CLR: taken = ~pv;
      `CFDEC_CC_SIGN_CLR: taken = ~sign;
      `CFDEC_CC_ZERO_CLR: taken = ~zero;
      `CFDEC_CC_CARRY_CLR: taken = ~carry;
      default: taken = 1'b0;
    endcase
  end
endmodule // cfdec_cond
`default_nettype wire

// File: logic/cfdec_flag.v
// one flag bit: applies the per-operation action to the held value
// assumes the action and computed value arrive together with the update strobe
`default_nettype none
module cfdec_flag (
  input wire [2:0] action,
  input wire computed,
  input wire held,
  output reg next_flag
);
`include "cfdec_map.vh"
  // undefined keeps the old value: cheapest legal choice
  always @* begin
    case (action)
      `CFDEC_FA_ZERO: next_flag = 1'b0;
      `CFDEC_FA_ONE: next_flag = 1'b1;
      `CFDEC_FA_CALC: next_flag = computed;
      `CFDEC_FA_UNDEF: next_flag = held;
      default: next_flag = held;
    endcase
  end
endmodule // cfdec_flag
`default_nettype wire

// File: logic/cfdec_top.v
// decoder top: prefix classing, operand fields, address forms, flags
// assumes fetch presents one byte per strobe and the datapath supplies
// register values; all on ref_clk
`default_nettype none
// constants first: the parameter defaults below already need them
`include "cfdec_map.vh"
module cfdec_top #(
  parameter STATE_NS = `CFDEC_STATE_NS,
  parameter CLK_NS = `CFDEC_CLK_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire byte_valid,
  input wire [7:0] byte_in,
  input wire [15:0] byte_addr,
  input wire [3:0] cc_in,
  input wire [7:0] flag_in,
  input wire [7:0] acc_val,
  input wire [15:0] main_pair_val,
  input wire [15:0] base_val,
  input wire [7:0] disp8,
  input wire [15:0] disp16,
  input wire [7:0] op_lo,
  input wire [7:0] op_hi,
  input wire [2:0] addr_mode,
  input wire [7:0] bit_field,
  input wire flag_upd,
  input wire [7:0] result,
  input wire [11:0] flag_act,
  input wire calc_pv,
  input wire calc_carry,
  input wire [7:0] state_count,
  input wire time_start,
  output reg cond_true,
  output reg need_second,
  output reg op_valid,
  output reg [7:0] op_first,
  output reg [7:0] op_second,
  output reg grp_src,
  output reg grp_dst,
  output reg grp_reg,
  output reg blk_or_ret,
  output reg [7:0] pair_sel,
  output reg [7:0] push_sel,
  output reg [7:0] idx_sel,
  output reg [2:0] byte_reg,
  output reg byte_is_acc,
  output reg [15:0] eff_addr,
  output reg [15:0] rel_target,
  output reg [7:0] bit_mask,
  output reg [7:0] flag_out,
  output reg time_done
);
  // ----------------------------------------
  // timing
  // ----------------------------------------
  // whole clocks per state; a clock that does not divide the state rounds down
  localparam integer CYC_INT = STATE_NS / CLK_NS;
  localparam [7:0] CYC_PER_STATE = CYC_INT[7:0]; // five at 25 MHz
  // prefix sequencer states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_SECOND = 3'b010;
  localparam ST_DONE = 3'b100;
  // address form select codes
  localparam [2:0] AM_DIRECT = 3'h0;
  localparam [2:0] AM_REGIDX = 3'h1;
  localparam [2:0] AM_INDEX = 3'h2;
  localparam [2:0] AM_EXTEND = 3'h3;
  localparam [2:0] AM_INDIRECT = 3'h4;
  localparam [2:0] AM_REL8 = 3'h5;
  localparam [2:0] AM_REL16 = 3'h6;

  // sequencer and decode working values
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] first_byte;
  reg pfx;
  reg [7:0] pair_dec;
  reg [7:0] push_dec;
  reg [7:0] idx_dec;
  reg [15:0] next_addr;
  reg [15:0] next_rel;
  reg [7:0] state_left;
  reg [7:0] cyc_left;
  wire taken;
  wire [7:0] next_flags;
  wire res_zero;
  wire [15:0] d8_ext;
  wire [15:0] acc_ext;

  // ----------------------------------------
  // condition evaluator
  // ----------------------------------------
  cfdec_cond u_cond (
    .cc(cc_in),
    .sign(flag_in[`CFDEC_FB_SIGN]),
    .zero(flag_in[`CFDEC_FB_ZERO]),
    .pv(flag_in[`CFDEC_FB_PV]),
    .carry(flag_in[`CFDEC_FB_CARRY]),
    .taken(taken)
  );

  // ----------------------------------------
  // flag update, four tracked flags
  // ----------------------------------------
  // all-zero test feeds the zero flag
  assign res_zero = (result == 8'h00);
  cfdec_flag u_sign (
    .action(flag_act[11:9]),
    .computed(result[7]),
    .held(flag_in[`CFDEC_FB_SIGN]),
    .next_flag(next_flags[`CFDEC_FB_SIGN])
  );
  cfdec_flag u_zero (
    .action(flag_act[8:6]),
    .computed(res_zero),
    .held(flag_in[`CFDEC_FB_ZERO]),
    .next_flag(next_flags[`CFDEC_FB_ZERO])
  );
  cfdec_flag u_pv (
    .action(flag_act[5:3]),
    .computed(calc_pv),
    .held(flag_in[`CFDEC_FB_PV]),
    .next_flag(next_flags[`CFDEC_FB_PV])
  );
  cfdec_flag u_carry (
    .action(flag_act[2:0]),
    .computed(calc_carry),
    .held(flag_in[`CFDEC_FB_CARRY]),
    .next_flag(next_flags[`CFDEC_FB_CARRY])
  );
  // untracked flags pass through unchanged
  assign next_flags[5:3] = flag_in[5:3];
  assign next_flags[1] = flag_in[1];

  // ----------------------------------------
  // operand field decode
  // ----------------------------------------
  // codes 3 and 7 have no pair: all-zero select
  always @* begin
    pair_dec = 8'h00;
    case (op_first[2:0])
      `CFDEC_PAIR_CNT: pair_dec[`CFDEC_RS_CNT] = 1'b1;
      `CFDEC_PAIR_SEC: pair_dec[`CFDEC_RS_SEC] = 1'b1;
      `CFDEC_PAIR_MAIN: pair_dec[`CFDEC_RS_MAIN] = 1'b1;
      `CFDEC_PAIR_IXF: pair_dec[`CFDEC_RS_IXF] = 1'b1;
      `CFDEC_PAIR_IXS: pair_dec[`CFDEC_RS_IXS] = 1'b1;
      `CFDEC_PAIR_SIX: pair_dec[`CFDEC_RS_STK] = 1'b1;
      default: pair_dec = 8'h00;
    endcase
    push_dec = pair_dec;
    if (op_first[2:0] == `CFDEC_PAIR_SIX) begin
      push_dec = 8'h00;
      push_dec[`CFDEC_RS_AF] = 1'b1;
    end
    idx_dec = 8'h00;
    case (op_first[1:0])
      `CFDEC_IDX_FIRST: idx_dec[`CFDEC_RS_IXF] = 1'b1;
      `CFDEC_IDX_SECOND: idx_dec[`CFDEC_RS_IXS] = 1'b1;
      `CFDEC_IDX_STACK: idx_dec[`CFDEC_RS_STK] = 1'b1;
      default: idx_dec = 8'h00;
    endcase
  end

  // ----------------------------------------
  // address forms
  // ----------------------------------------
  // sign extension of the signed byte fields
  assign d8_ext = {{8{disp8[7]}}, disp8};
  assign acc_ext = {{8{acc_val[7]}}, acc_val};
  // effective address and relative target, recomputed every cycle
  always @* begin
    case (addr_mode)
      AM_DIRECT: next_addr = {`CFDEC_DIRECT_PAGE, op_lo};
      AM_REGIDX: next_addr = main_pair_val + acc_ext;
      AM_INDEX: next_addr = base_val + d8_ext;
      AM_EXTEND: next_addr = {op_hi, op_lo};
      AM_INDIRECT: next_addr = base_val;
      default: next_addr = base_val;
    endcase
    // wraps modulo 64K like the program counter
    if (addr_mode == AM_REL16) begin
      next_rel = byte_addr + `CFDEC_REL_BIAS + disp16;
    end else begin
      next_rel = byte_addr + `CFDEC_REL_BIAS + d8_ext;
    end
  end

  // ----------------------------------------
  // prefix sequencing
  // ----------------------------------------
  // prefix test and next sequencer state
  always @* begin
    pfx = (byte_in >= `CFDEC_PFX_LO) && (byte_in <= `CFDEC_PFX_HI);
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (byte_valid) begin
          next_state = pfx ? ST_SECOND : ST_DONE;
        end
      end
      ST_SECOND: begin
        if (byte_valid) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = byte_valid ? (pfx ? ST_SECOND : ST_DONE) : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // byte capture; a one-byte opcode clears the classes of the last prefix
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      first_byte <= 8'h00;
      op_valid <= 1'b0;
      op_first <= 8'h00;
      op_second <= 8'h00;
      need_second <= 1'b0;
      grp_src <= 1'b0;
      grp_dst <= 1'b0;
      grp_reg <= 1'b0;
      blk_or_ret <= 1'b0;
    end else begin
      state <= next_state;
      op_valid <= 1'b0;
      if (byte_valid && state != ST_SECOND) begin
        first_byte <= byte_in;
        need_second <= pfx;
        if (!pfx) begin
          op_first <= byte_in;
          op_second <= 8'h00;
          op_valid <= 1'b1;
          grp_src <= 1'b0;
          grp_dst <= 1'b0;
          grp_reg <= 1'b0;
          blk_or_ret <= 1'b0;
        end
      end else if (byte_valid) begin
        // operation resolves only once the second byte is in
        need_second <= 1'b0;
        op_first <= first_byte;
        op_second <= byte_in;
        op_valid <= 1'b1;
        grp_src <= (first_byte <= `CFDEC_SRC_A_HI) ||
          (first_byte >= `CFDEC_SRC_B_LO && first_byte <= `CFDEC_SRC_B_HI);
        grp_dst <= (first_byte >= `CFDEC_DST_A_LO && first_byte <= `CFDEC_DST_A_HI) ||
          (first_byte >= `CFDEC_DST_B_LO && first_byte <= `CFDEC_DST_B_HI);
        grp_reg <= (first_byte >= `CFDEC_REG_LO);
        blk_or_ret <= (first_byte == `CFDEC_BLOCK_PFX) &&
          ((byte_in[7:3] == `CFDEC_BLK_TOP) || (byte_in[7:4] == `CFDEC_RET_TOP));
      end
    end
  end

  // ----------------------------------------
  // registered operand, address and flag outputs
  // ----------------------------------------
  // outputs follow their inputs one clock later
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond_true <= 1'b0;
      pair_sel <= 8'h00;
      push_sel <= 8'h00;
      idx_sel <= 8'h00;
      byte_reg <= 3'h0;
      byte_is_acc <= 1'b0;
      eff_addr <= 16'h0000;
      rel_target <= 16'h0000;
      bit_mask <= 8'h00;
      flag_out <= 8'h00;
    end else begin
      cond_true <= taken;
      pair_sel <= pair_dec;
      push_sel <= push_dec;
      idx_sel <= idx_dec;
      byte_reg <= op_first[2:0];
      byte_is_acc <= (op_first[2:0] == `CFDEC_REG_ACC);
      eff_addr <= next_addr;
      rel_target <= next_rel;
      bit_mask <= 8'h01 << bit_field[2:0];
      if (flag_upd) begin
        flag_out <= next_flags;
      end else begin
        flag_out <= flag_in;
      end
    end
  end

  // ----------------------------------------
  // state timer: counts states of CYC_PER_STATE clocks
  // ----------------------------------------
  // a new start restarts the count, even in the middle of one
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_left <= 8'h00;
      cyc_left <= 8'h00;
      time_done <= 1'b0;
    end else begin
      time_done <= 1'b0;
      if (time_start) begin
        state_left <= state_count;
        cyc_left <= CYC_PER_STATE - 8'h01;
      end else if (state_left != 8'h00) begin
        if (cyc_left == 8'h00) begin
          cyc_left <= CYC_PER_STATE - 8'h01;
          state_left <= state_left - 8'h01;
          time_done <= (state_left == 8'h01);
        end else begin
          cyc_left <= cyc_left - 8'h01;
        end
      end
    end
  end
endmodule // cfdec_top
`default_nettype wire

// File: verification/cfdec_checker.sv
// checker: timing relations at the decoder top ports
// assumes it is bound onto cfdec_top, everything on ref_clk
`default_nettype none
module cfdec_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [15:0] byte_addr,
  input wire logic [3:0] cc_in,
  input wire logic [7:0] flag_in,
  input wire logic [7:0] disp8,
  input wire logic [7:0] op_lo,
  input wire logic [2:0] addr_mode,
  input wire logic [7:0] bit_field,
  input wire logic flag_upd,
  input wire logic [7:0] result,
  input wire logic [11:0] flag_act,
  input wire logic cond_true,
  input wire logic need_second,
  input wire logic op_valid,
  input wire logic [7:0] op_first,
  input wire logic grp_src,
  input wire logic grp_dst,
  input wire logic blk_or_ret,
  input wire logic [15:0] eff_addr,
  input wire logic [15:0] rel_target,
  input wire logic [7:0] bit_mask,
  input wire logic [7:0] flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] exp_rel;
  logic sv;
  logic zs;
  logic cz;
  // ------
  // helper terms
  // ------
  // target kept one cycle so the assertion compares like with like
  always_ff @(posedge ref_clk) begin
    exp_rel <= byte_addr + 16'h0002 + {{8{disp8[7]}}, disp8};
  end
  // flag terms of the signed and unsigned compares
  assign sv = flag_in[7] ^ flag_in[2];
  assign zs = flag_in[6] | sv;
  assign cz = flag_in[0] | flag_in[6];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------
  // prefix sequences
  // ------
  sequence s_src_first;
    byte_valid && !need_second && (byte_in inside {[8'hE0:8'hE7], [8'hF0:8'hF3]});
  endsequence
  sequence s_dst_first;
    byte_valid && !need_second && (byte_in inside {[8'hE8:8'hEF], [8'hF4:8'hF7]});
  endsequence
  sequence s_second;
    byte_valid && need_second;
  endsequence
  a_cond_snotbelow: assert property (cc_in == 4'h9 |=> cond_true == !$past(sv))
    else $error("signed not-below wrong");
  a_cond_sabove: assert property (cc_in == 4'hA |=> cond_true == !$past(zs))
    else $error("signed above wrong");
  a_cond_uatmost: assert property (cc_in == 4'h3 |=> cond_true == $past(cz))
    else $error("unsigned at-most wrong");
  a_prefix_wait: assert property (byte_valid && !need_second &&
    (byte_in inside {[8'hE0:8'hFE]}) |=> need_second && !op_valid)
    else $error("prefix did not wait");
  a_src_group: assert property (s_src_first ##1 s_second |=> op_valid && grp_src && !grp_dst)
    else $error("source group wrong");
  a_dst_group: assert property (s_dst_first ##1 s_second |=> op_valid && grp_dst && !grp_src)
    else $error("destination group wrong");
  a_blk_only_fe: assert property (op_valid && blk_or_ret |-> op_first == 8'hFE)
    else $error("block class without FE");
  a_direct_page: assert property (addr_mode == 3'h0 |=> eff_addr == {8'hFF, $past(op_lo)})
    else $error("direct address wrong");
  a_rel_short: assert property (addr_mode == 3'h5 |=> rel_target == exp_rel)
    else $error("relative target wrong");
  a_bit_one: assert property (1'b1 |=> bit_mask == 8'h01 << ($past(bit_field) & 8'h07))
    else $error("bit mask wrong");
  a_sign_load: assert property (flag_upd && flag_act[11:9] == 3'h3 |=>
    flag_out[7] == ($past(result) >= 8'h80))
    else $error("sign flag wrong");
  a_zero_load: assert property (flag_upd && flag_act[8:6] == 3'h3 |=>
    flag_out[6] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
endmodule // cfdec_checker
bind cfdec_top cfdec_checker i_chk (.*);
`default_nettype wire

// File: verification/cfdec_fetch_model.sv
// fetch side model: hands opcode bytes to the decoder one per strobe
// assumes send is called from one process at a time
`default_nettype none
module cfdec_fetch_model (
  input wire logic ref_clk,
  output logic byte_valid,
  output logic [7:0] byte_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    byte_valid = 1'b0;
    byte_in = 8'h5A;
  end
  // released bus shows the inverse so a stale byte never looks valid
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    @(negedge ref_clk);
    byte_valid = 1'b1;
    byte_in = b0;
    if (two) begin
      @(negedge ref_clk);
      byte_in = b1;
    end
    @(negedge ref_clk);
    byte_valid = 1'b0;
    byte_in = ~byte_in;
  endtask
endmodule // cfdec_fetch_model
`default_nettype wire

// File: verification/cfdec_top_test.sv
// bench for the decoder top: conditions, prefixes, operands, flags, timer
// assumes the fetch model drives the byte strobe, bench drives the rest
`default_nettype none
`include "cfdec_map.vh"
module cfdec_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, byte_valid, flag_upd, calc_pv, calc_carry, time_start;
  logic [7:0] byte_in, flag_in, acc_val, disp8, op_lo, op_hi, bit_field, result, state_count;
  logic [15:0] byte_addr, main_pair_val, base_val, disp16;
  logic [3:0] cc_in;
  logic [2:0] addr_mode, byte_reg;
  logic [11:0] flag_act;
  logic cond_true, need_second, op_valid, grp_src, grp_dst, grp_reg, blk_or_ret;
  logic byte_is_acc, time_done;
  logic [7:0] op_first, op_second, pair_sel, push_sel, idx_sel, bit_mask, flag_out;
  logic [15:0] eff_addr, rel_target;
  logic [7:0] fe_sec[7] = '{8'h57, 8'h58, 8'h5F, 8'h60, 8'hCF, 8'hD0, 8'hDF};
  int errors, n_tests, n;
  cfdec_top i_dut (.*);
  cfdec_fetch_model i_fetch (.*);
  // ------
  // helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic cond_exp(input logic [3:0] c, input logic [7:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[7] ^ f[2];
      3'h2: r = f[6] | (f[7] ^ f[2]);
      3'h3: r = f[0] | f[6];
      3'h4: r = f[2];
      3'h5: r = f[7];
      3'h6: r = f[6];
      default: r = f[0];
    endcase
    return r ^ c[3];
  endfunction
  // {src, dst, reg, block}
  function automatic logic [3:0] grp_exp(input logic [7:0] a, input logic [7:0] b);
    return {a inside {[8'hE0:8'hE7], [8'hF0:8'hF3]}, a inside {[8'hE8:8'hEF], [8'hF4:8'hF7]},
      a inside {[8'hF8:8'hFE]}, a == 8'hFE && (b[7:3] == 5'h0B || b[7:4] == 4'hD)};
  endfunction
  // k: 0 general pair, 1 push/pop pair, 2 index field
  function automatic logic [7:0] sel_exp(input logic [2:0] c, input int k);
    if (k == 2) return (c < 3'h3) ? 8'h08 << c : 8'h00;
    case (c)
      3'h0, 3'h1, 3'h2: return 8'h01 << c;
      3'h4, 3'h5: return 8'h08 << (c - 3'h4);
      3'h6: return (k == 1) ? 8'h40 : 8'h20;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [15:0] sx8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction
  function automatic logic fa(input logic [2:0] a, input logic h, input logic c);
    case (a)
      3'h1: return 1'b0;
      3'h2: return 1'b1;
      3'h3: return c;
      default: return h;
    endcase
  endfunction
  function automatic logic [7:0] flags_exp();
    logic [7:0] o;
    o = flag_in;
    if (flag_upd) begin
      o[7] = fa(flag_act[11:9], o[7], result[7]);
      o[6] = fa(flag_act[8:6], o[6], result == 8'h00);
      o[2] = fa(flag_act[5:3], o[2], calc_pv);
      o[0] = fa(flag_act[2:0], o[0], calc_carry);
    end
    return o;
  endfunction
  // one opcode through the model, then its classes and selects
  task automatic op_run(input logic [7:0] a, input logic [7:0] b, input bit two);
    i_fetch.send(a, b, two);
    check(op_valid, 1'b1);
    check({op_first, op_second}, {a, two ? b : 8'h00});
    if (two) check({grp_src, grp_dst, grp_reg, blk_or_ret}, grp_exp(a, b));
    @(negedge ref_clk);
    check(op_valid, 1'b0);
    check({pair_sel, push_sel}, {sel_exp(a[2:0], 0), sel_exp(a[2:0], 1)});
    if (a[7:2] == 6'h3C) check(idx_sel, sel_exp({1'b0, a[1:0]}, 2));
    check({byte_reg, byte_is_acc}, {a[2:0], a[2:0] == 3'h6});
  endtask
  // ------
  // clock and sequence
  // ------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1'b1;
    {cc_in, flag_in, acc_val, main_pair_val, base_val, disp8, disp16, op_lo, op_hi,
      addr_mode, bit_field, flag_upd, result, flag_act, calc_pv, calc_carry, state_count,
      time_start, byte_addr} = '0;
    void'($urandom(96133));
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    for (int i = 0; i < 64; i++) begin
      cc_in = i[3:0];
      flag_in = 8'($urandom);
      @(negedge ref_clk);
      check(cond_true, cond_exp(cc_in, flag_in));
      check(flag_out, flag_in);
    end
    for (int a = 224; a < 255; a++) op_run(8'(a), 8'($urandom), 1'b1);
    foreach (fe_sec[k]) op_run(8'hFE, fe_sec[k], 1'b1);
    op_run(8'hDF, 8'h00, 1'b0);
    op_run(8'hFF, 8'h00, 1'b0);
    // operand forms, first corners then random
    for (int i = 0; i < 70; i++) begin
      addr_mode = 3'(i % 7);
      {acc_val, disp8, disp16} = (i < 7) ? 32'h8080_8000 : (i < 14) ? 32'h7F7F_7FFF : $urandom;
      {main_pair_val, base_val} = $urandom;
      {byte_addr, op_lo, op_hi} = $urandom;
      bit_field = 8'($urandom);
      @(negedge ref_clk);
      check(bit_mask, 8'h01 << bit_field[2:0]);
      case (addr_mode)
        3'h0: check(eff_addr, {8'hFF, op_lo});
        3'h1: check(eff_addr, 16'(main_pair_val + sx8(acc_val)));
        3'h2: check(eff_addr, 16'(base_val + sx8(disp8)));
        3'h3: check(eff_addr, {op_hi, op_lo});
        3'h5: check(rel_target, 16'(byte_addr + 16'h0002 + sx8(disp8)));
        3'h6: check(rel_target, 16'(byte_addr + 16'h0002 + disp16));
        default: ;
      endcase
    end
    // every flag action with zero results mixed in
    for (int i = 0; i < 80; i++) begin
      flag_upd = (i % 4) != 0;
      flag_act = {3'($urandom_range(4)), 3'($urandom_range(4)), 3'($urandom_range(4)),
        3'($urandom_range(4))};
      {flag_in, calc_pv, calc_carry} = 10'($urandom);
      result = (i % 5 == 0) ? 8'h00 : 8'($urandom);
      @(negedge ref_clk);
      check(flag_out, flags_exp());
    end
    // state timer, bounded wait
    for (int s = 1; s < 4; s += 2) begin
      state_count = 8'(s);
      time_start = 1'b1;
      @(negedge ref_clk);
      time_start = 1'b0;
      n = 0;
      while (time_done !== 1'b1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      check(n, s * (`CFDEC_STATE_NS / `CFDEC_CLK_NS));
      if (n == 100) break;
    end
    print_verdict();
  end
endmodule // cfdec_top_test
`default_nettype wire
